// ### rtl/bmu_pkg.sv
/*
  bmu_pkg: register offsets, field positions, constants and state codes of the
  block move unit. Assumes word-aligned offsets on an 8-bit register address.
  Field positions inside the command byte are the first-word bits 31-24.
*/
package bmu_pkg;
  localparam logic [7:0] A_PTR = 8'h00;
  localparam logic [7:0] A_MODE = 8'h04;
  localparam logic [7:0] A_CTL1 = 8'h08;
  localparam logic [7:0] A_CTL2 = 8'h0C;
  localparam logic [7:0] A_DSA = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_CMD = 8'h18;
  localparam logic [7:0] A_NAD = 8'h1C;
  localparam logic [7:0] A_OPD = 8'h20;
  localparam logic [7:0] A_PHR = 8'h24;
  // transfer_mode_register
  localparam int B_SRC = 5;
  localparam int B_DST = 4;
  // bus_control_one
  localparam int B_TGT = 0;
  localparam int B_ATN = 1;
  localparam int B_CACK = 2;
  localparam int B_DISH = 3;
  // bus_control_two
  localparam int B_VUE = 1;
  // status
  localparam int F_ILL = 0;
  localparam int F_MIS = 1;
  localparam int F_HLT = 2;
  localparam int F_DONE = 3;
  localparam int F_BUSY = 4;
  localparam int F_ST = 8;
  // command byte: [7:6] type, 5 indirect, 4 table, 3 op, [2:0] phase
  localparam int C_IND = 5;
  localparam int C_TBL = 4;
  localparam int C_OP = 3;
  localparam int P_IO = 0;
  localparam int OFS_MSB = 23;
  localparam logic [1:0] T_BMOVE = 2'h0;
  localparam logic [2:0] PH_CMD = 3'h2;
  localparam logic [2:0] PH_MOUT = 3'h6;
  localparam logic [2:0] PH_MIN = 3'h7;
  localparam logic [2:0] G_6 = 3'h0;
  localparam logic [2:0] G_10A = 3'h1;
  localparam logic [2:0] G_10B = 3'h2;
  localparam logic [2:0] G_12 = 3'h5;
  localparam logic [23:0] LEN6 = 24'h000006;
  localparam logic [23:0] LEN10 = 24'h00000A;
  localparam logic [23:0] LEN12 = 24'h00000C;
  localparam logic [23:0] CNT0 = 24'h000000;
  localparam logic [23:0] CNT1 = 24'h000001;
  localparam logic [31:0] STEP_B = 32'h00000001;
  localparam logic [31:0] STEP_W = 32'h00000004;
  localparam logic [31:0] STEP_I = 32'h00000008;
  localparam int R_RES = 8;
  localparam int R_RESV = 16;
  localparam int R_ODLV = 17;
  localparam int R_ODL = 24;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_F0 = 4'h1, S_F1 = 4'h2, S_DEC = 4'h3,
    S_IND = 4'h4, S_TCNT = 4'h5, S_TADR = 4'h6, S_CHK = 4'h7,
    S_WREQ = 4'h8, S_START = 4'h9, S_MEM = 4'hA, S_HON = 4'hB,
    S_HOFF = 4'hC, S_FIN = 4'hD, S_HALT = 4'hE
  } bmu_state_e;
endpackage : bmu_pkg

// ### rtl/bmu_unit.sv
/*
  bmu_unit: block move instruction unit; fetches, decodes and runs one move
  at a time between memory and the bus, byte by byte.
  Assumes same-clock fetch and memory ports that answer with a one-cycle ack
  while the request stands; bus pins arrive unsynchronised, true-level.
*/
// Our own choices: the strobed register port and the register offsets.
// How it works
// RULE1 - first word to command/count, second to operand
// RULE2 - space bits pick memory or I/O
// RULE3 - bits 31-30 select block move type
// RULE4 - direct: operand becomes next address
// RULE5 - indirect: third fetch loads next address
// RULE6 - script never sets both addressing bits
// RULE7 - table address is base plus signed offset
// RULE8 - table entry: count, then address, then move
// RULE9 - table entries contiguous, count word first
// RULE10 - bit 27 meaning depends on role
// RULE11 - check connected in configured role first
// RULE12 - target drives phase lines from field
// RULE13 - command group overrides count: 6,10,12
// RULE14 - vendor bit or group keeps count
// RULE15 - other groups keep count; zero is illegal
// RULE16 - target chained odd receive keeps residue
// RULE17 - attention or parity error halts target
// RULE18 - initiator waits for unserviced request
// RULE19 - phase compare; mismatch interrupts, no transfer
// RULE20 - initiator chained odd end keeps byte
// RULE21 - message out drops attention last handshake
// RULE22 - message in leaves acknowledge asserted
// RULE23 - phase field: message, command/data, input/output
// RULE24 - count down, address up, then refetch
// RULE25 - table mode ignores first-word count
`timescale 1ns/1ns
`default_nettype none
module bmu_unit (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic FETCH_REQ,
  output logic [31:0] FETCH_ADDR,
  input wire logic FETCH_ACK,
  input wire logic [31:0] FETCH_DATA,
  output logic DMA_REQ,
  output logic DMA_WE,
  output logic DMA_IO,
  output logic [31:0] DMA_ADDR,
  output logic [7:0] DMA_WDATA,
  input wire logic DMA_ACK,
  input wire logic [7:0] DMA_RDATA,
  input wire logic CONN_TARGET,
  input wire logic CONN_INIT,
  input wire logic REQ_I,
  input wire logic ACK_I,
  input wire logic ATN_I,
  input wire logic [2:0] PHASE_I,
  input wire logic [7:0] DB_I,
  input wire logic DBP_I,
  output logic REQ_O,
  output logic ACK_O,
  output logic ATN_O,
  output logic [2:0] PHASE_O,
  output logic PHASE_OE,
  output logic [7:0] DB_O,
  output logic DBP_O,
  output logic DB_OE
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // odd parity bit for a byte
  function automatic logic oddp(input logic [7:0] d);
    oddp = ~(^d);
  endfunction : oddp

  bmu_pkg::bmu_state_e state_ff, nxt_state;
  logic [14:0] s1_ff, s2_ff;
  logic req_q_ff;
  logic [7:0] mode_ff, ctl1_ff, ctl2_ff;
  logic [31:0] dsa_ff, rdata_ff;
  logic [3:0] flags_ff, nxt_flags, ev;
  logic [2:0] plat_ff;
  logic [31:0] ptr_ff, nxt_ptr, opd_ff, nxt_opd, nad_ff, nxt_nad;
  logic [7:0] cmd_ff, nxt_cmd;
  logic [23:0] cnt_ff, nxt_cnt;
  logic freq_ff, nxt_freq, dreq_ff, nxt_dreq, dwe_ff, nxt_dwe, dio_ff, nxt_dio;
  logic [31:0] fadr_ff, nxt_fadr, dadr_ff, nxt_dadr;
  logic [7:0] dwd_ff, nxt_dwd, dbo_ff, nxt_dbo, res_ff, nxt_res, odl_ff, nxt_odl;
  logic reqo_ff, nxt_reqo, acko_ff, nxt_acko, atno_ff, nxt_atno;
  logic [2:0] pho_ff, nxt_pho;
  logic phoe_ff, nxt_phoe, dbp_ff, nxt_dbp, dboe_ff, nxt_dboe;
  logic first_ff, nxt_first, odd_ff, nxt_odd, flush_ff, nxt_flush;
  logic hpend_ff, nxt_hpend, resv_ff, nxt_resv, odlv_ff, nxt_odlv;

  // data lines settle before the handshake edge is seen, so a 15-bit
  // two-stage sync stays coherent when it is read in the handshake states
  wire [14:0] pins = {REQ_I, ACK_I, ATN_I, PHASE_I, DB_I, DBP_I};
  wire req_s = s2_ff[14];
  wire ack_s = s2_ff[13];
  wire atn_s = s2_ff[12];
  wire [2:0] ph_s = s2_ff[11:9];
  wire [7:0] db_s = s2_ff[8:1];
  wire dbp_s = s2_ff[0];

  wire wr_ptr = WR && hit(ADDR, bmu_pkg::A_PTR);
  wire wr_c1 = WR && hit(ADDR, bmu_pkg::A_CTL1);
  wire wr_atn = wr_c1 && WDATA[bmu_pkg::B_ATN];
  wire wr_cack = wr_c1 && WDATA[bmu_pkg::B_CACK];
  wire wr_stat = WR && hit(ADDR, bmu_pkg::A_STAT);

  wire tgt = ctl1_ff[bmu_pkg::B_TGT];
  wire dish = ctl1_ff[bmu_pkg::B_DISH];
  wire vue = ctl2_ff[bmu_pkg::B_VUE];
  wire [1:0] itype = cmd_ff[7:6]; // RULE3
  wire is_ind = cmd_ff[bmu_pkg::C_IND];
  wire is_tbl = cmd_ff[bmu_pkg::C_TBL];
  wire opb = cmd_ff[bmu_pkg::C_OP];
  wire [2:0] phase = cmd_ff[2:0]; // RULE23
  wire chained = tgt ? opb : ~opb; // RULE10
  wire sending = tgt ? phase[bmu_pkg::P_IO] : ~phase[bmu_pkg::P_IO];
  wire space_io = sending ? mode_ff[bmu_pkg::B_SRC] : mode_ff[bmu_pkg::B_DST]; // RULE2
  wire connected = tgt ? CONN_TARGET : CONN_INIT; // RULE11
  wire [31:0] sext = {{8{opd_ff[bmu_pkg::OFS_MSB]}}, opd_ff[23:0]};
  wire [31:0] tbl_adr = dsa_ff + sext; // RULE7
  wire [2:0] grp = dwd_ff[7:5];
  wire g6 = (grp == bmu_pkg::G_6);
  wire g10 = (grp == bmu_pkg::G_10A) || (grp == bmu_pkg::G_10B);
  wire g12 = (grp == bmu_pkg::G_12);
  wire ovr = !vue && (g6 || g10 || g12); // RULE13 RULE14
  wire [23:0] cdb_len = g6 ? bmu_pkg::LEN6 : (g10 ? bmu_pkg::LEN10 : bmu_pkg::LEN12);
  wire last_rx = (cnt_ff == bmu_pkg::CNT1);
  wire keep_odd = chained && !odd_ff && last_rx; // RULE16 RULE20
  wire fdone = freq_ff && FETCH_ACK;
  wire ddone = dreq_ff && DMA_ACK;
  wire busy = (state_ff != bmu_pkg::S_IDLE) && (state_ff != bmu_pkg::S_HALT);

  wire [31:0] stat_w = {20'h00000, state_ff, 3'h0, busy, flags_ff};
  wire [31:0] phr_w = {odl_ff, 6'h00, odlv_ff, resv_ff, res_ff, 5'h00, plat_ff};
  wire [31:0] rd_w =
    hit(ADDR, bmu_pkg::A_PTR) ? ptr_ff :
    hit(ADDR, bmu_pkg::A_MODE) ? {24'h000000, mode_ff} :
    hit(ADDR, bmu_pkg::A_CTL1) ? {24'h000000, ctl1_ff} :
    hit(ADDR, bmu_pkg::A_CTL2) ? {24'h000000, ctl2_ff} :
    hit(ADDR, bmu_pkg::A_DSA) ? dsa_ff :
    hit(ADDR, bmu_pkg::A_STAT) ? stat_w :
    hit(ADDR, bmu_pkg::A_CMD) ? {cmd_ff, cnt_ff} :
    hit(ADDR, bmu_pkg::A_NAD) ? nad_ff :
    hit(ADDR, bmu_pkg::A_OPD) ? opd_ff :
    hit(ADDR, bmu_pkg::A_PHR) ? phr_w : 32'h00000000;

  // set wins over a write-one-to-clear in the same cycle
  wire [3:0] w1c = wr_stat ? WDATA[3:0] : 4'h0;
  assign nxt_flags = (flags_ff & ~w1c) | ev;

  always_comb begin
    nxt_state = state_ff;
    nxt_ptr = ptr_ff;
    nxt_opd = opd_ff;
    nxt_nad = nad_ff;
    nxt_cmd = cmd_ff;
    nxt_cnt = cnt_ff;
    nxt_freq = freq_ff;
    nxt_fadr = fadr_ff;
    nxt_dreq = dreq_ff;
    nxt_dwe = dwe_ff;
    nxt_dio = dio_ff;
    nxt_dadr = dadr_ff;
    nxt_dwd = dwd_ff;
    nxt_dbo = dbo_ff;
    nxt_dbp = dbp_ff;
    nxt_dboe = dboe_ff;
    nxt_reqo = reqo_ff;
    nxt_acko = acko_ff;
    nxt_atno = atno_ff;
    nxt_pho = pho_ff;
    nxt_phoe = phoe_ff && tgt;
    nxt_first = first_ff;
    nxt_odd = odd_ff;
    nxt_flush = flush_ff;
    nxt_hpend = hpend_ff;
    nxt_res = res_ff;
    nxt_resv = resv_ff;
    nxt_odl = odl_ff;
    nxt_odlv = odlv_ff;
    ev = 4'h0;
    if (wr_atn) begin
      nxt_atno = 1'b1;
    end
    if (wr_cack) begin
      nxt_acko = 1'b0; // RULE22
    end
    case (state_ff)
      bmu_pkg::S_IDLE, bmu_pkg::S_HALT: begin
        if (wr_ptr) begin
          nxt_ptr = WDATA;
          nxt_state = bmu_pkg::S_F0;
        end
      end
      bmu_pkg::S_F0: begin
        nxt_freq = !fdone;
        nxt_fadr = ptr_ff;
        if (fdone) begin
          nxt_cmd = FETCH_DATA[31:24]; // RULE1
          nxt_cnt = FETCH_DATA[23:0]; // RULE24
          nxt_state = bmu_pkg::S_F1;
        end
      end
      bmu_pkg::S_F1: begin
        nxt_freq = !fdone;
        nxt_fadr = ptr_ff + bmu_pkg::STEP_W;
        if (fdone) begin
          nxt_opd = FETCH_DATA; // RULE1
          nxt_ptr = ptr_ff + bmu_pkg::STEP_I;
          nxt_state = bmu_pkg::S_DEC;
        end
      end
      bmu_pkg::S_DEC: begin
        // both addressing bits set is a script fault; table wins here
        if (itype != bmu_pkg::T_BMOVE) begin // RULE3
          ev[bmu_pkg::F_ILL] = 1'b1;
          nxt_state = bmu_pkg::S_HALT;
        end else if (is_tbl) begin
          nxt_state = bmu_pkg::S_TCNT; // RULE6
        end else if (is_ind) begin
          nxt_state = bmu_pkg::S_IND;
        end else begin
          nxt_nad = opd_ff; // RULE4
          nxt_state = bmu_pkg::S_CHK;
        end
      end
      bmu_pkg::S_IND: begin
        nxt_freq = !fdone;
        nxt_fadr = opd_ff;
        if (fdone) begin
          nxt_nad = FETCH_DATA; // RULE5
          nxt_state = bmu_pkg::S_CHK;
        end
      end
      bmu_pkg::S_TCNT: begin
        nxt_freq = !fdone;
        nxt_fadr = tbl_adr;
        if (fdone) begin
          nxt_cnt = FETCH_DATA[23:0]; // RULE8 RULE25 RULE9
          nxt_state = bmu_pkg::S_TADR;
        end
      end
      bmu_pkg::S_TADR: begin
        nxt_freq = !fdone;
        nxt_fadr = tbl_adr + bmu_pkg::STEP_W;
        if (fdone) begin
          nxt_nad = FETCH_DATA; // RULE8
          nxt_state = bmu_pkg::S_CHK;
        end
      end
      bmu_pkg::S_CHK: begin
        nxt_first = 1'b1;
        nxt_hpend = 1'b0;
        nxt_odd = 1'b0;
        if (!connected) begin // RULE11
          ev[bmu_pkg::F_ILL] = 1'b1;
          nxt_state = bmu_pkg::S_HALT;
        end else if (tgt) begin
          nxt_pho = phase; // RULE12
          nxt_phoe = 1'b1;
          if (cnt_ff == bmu_pkg::CNT0 && phase != bmu_pkg::PH_CMD) begin
            nxt_state = bmu_pkg::S_FIN;
          end else begin
            nxt_state = bmu_pkg::S_START;
          end
        end else begin
          nxt_state = bmu_pkg::S_WREQ;
        end
      end
      bmu_pkg::S_WREQ: begin
        // two cycles of request so the latched phase is up to date
        if (req_s && req_q_ff && !acko_ff) begin // RULE18
          if (plat_ff != phase) begin // RULE19
            ev[bmu_pkg::F_MIS] = 1'b1;
            nxt_state = bmu_pkg::S_HALT;
          end else if (cnt_ff == bmu_pkg::CNT0) begin
            nxt_state = bmu_pkg::S_FIN;
          end else begin
            nxt_state = bmu_pkg::S_START;
          end
        end
      end
      bmu_pkg::S_START: begin
        // a byte kept from the previous chained move goes out first
        if (sending && odlv_ff) begin // RULE20
          nxt_flush = 1'b1;
          nxt_odlv = 1'b0;
          nxt_dbo = odl_ff;
          nxt_dbp = oddp(odl_ff);
          nxt_dboe = 1'b1;
          nxt_state = bmu_pkg::S_HON;
        end else if (!sending && resv_ff) begin // RULE16 RULE20
          nxt_flush = 1'b1;
          nxt_dwd = res_ff;
          nxt_state = bmu_pkg::S_MEM;
        end else if (sending) begin
          nxt_state = bmu_pkg::S_MEM;
        end else begin
          nxt_state = bmu_pkg::S_HON;
        end
      end
      bmu_pkg::S_MEM: begin
        nxt_dreq = !ddone;
        nxt_dadr = nad_ff;
        nxt_dio = space_io; // RULE2
        nxt_dwe = flush_ff || !sending;
        if (ddone) begin
          nxt_nad = nad_ff + bmu_pkg::STEP_B; // RULE24
          if (flush_ff) begin
            nxt_flush = 1'b0;
            nxt_resv = 1'b0;
            nxt_state = bmu_pkg::S_HON;
          end else begin
            nxt_cnt = cnt_ff - bmu_pkg::CNT1; // RULE24
            nxt_odd = !odd_ff;
            if (sending && keep_odd) begin
              nxt_odl = DMA_RDATA; // RULE20
              nxt_odlv = 1'b1;
              nxt_state = bmu_pkg::S_FIN;
            end else if (sending) begin
              nxt_dbo = DMA_RDATA;
              nxt_dbp = oddp(DMA_RDATA);
              nxt_dboe = 1'b1;
              nxt_state = bmu_pkg::S_HON;
            end else if (last_rx) begin
              nxt_state = bmu_pkg::S_FIN; // RULE24
            end else begin
              nxt_state = bmu_pkg::S_HON;
            end
          end
        end
      end
      bmu_pkg::S_HON: begin
        if (tgt) begin
          nxt_reqo = !(reqo_ff && ack_s);
          if (atn_s) begin
            nxt_hpend = 1'b1; // RULE17
          end
          if (reqo_ff && ack_s) begin
            if (!sending) begin
              nxt_dwd = db_s;
              if (dbp_s != oddp(db_s)) begin
                nxt_hpend = 1'b1; // RULE17
              end
            end
            nxt_state = bmu_pkg::S_HOFF;
          end
        end else if (req_s && !acko_ff) begin
          if (!sending) begin
            nxt_dwd = db_s;
          end
          nxt_acko = 1'b1;
          if (sending && phase == bmu_pkg::PH_MOUT && cnt_ff == bmu_pkg::CNT0) begin
            nxt_atno = 1'b0; // RULE21
          end
          nxt_state = bmu_pkg::S_HOFF;
        end
      end
      bmu_pkg::S_HOFF: begin
        if (tgt ? !ack_s : !req_s) begin
          if (!tgt && !(!sending && phase == bmu_pkg::PH_MIN && last_rx)) begin
            nxt_acko = 1'b0; // RULE22
          end
          nxt_dboe = 1'b0;
          nxt_first = 1'b0;
          nxt_flush = 1'b0;
          if (tgt && hpend_ff && !dish) begin
            ev[bmu_pkg::F_HLT] = 1'b1; // RULE17
            nxt_state = bmu_pkg::S_HALT;
          end else if (tgt && first_ff && phase == bmu_pkg::PH_CMD) begin
            if (ovr) begin
              nxt_cnt = cdb_len; // RULE13
              nxt_state = bmu_pkg::S_MEM;
            end else if (cnt_ff == bmu_pkg::CNT0) begin
              ev[bmu_pkg::F_ILL] = 1'b1; // RULE15
              nxt_state = bmu_pkg::S_HALT;
            end else begin
              nxt_state = bmu_pkg::S_MEM; // RULE14
            end
          end else if (sending) begin
            nxt_state = (cnt_ff == bmu_pkg::CNT0) ? bmu_pkg::S_FIN : bmu_pkg::S_MEM;
          end else if (keep_odd) begin
            nxt_res = dwd_ff; // RULE16 RULE20
            nxt_resv = 1'b1;
            nxt_cnt = bmu_pkg::CNT0;
            nxt_odd = 1'b1;
            nxt_state = bmu_pkg::S_FIN;
          end else begin
            nxt_state = bmu_pkg::S_MEM;
          end
        end
      end
      bmu_pkg::S_FIN: begin
        if (tgt && hpend_ff) begin
          ev[bmu_pkg::F_HLT] = 1'b1; // RULE17
          nxt_state = bmu_pkg::S_HALT;
        end else begin
          ev[bmu_pkg::F_DONE] = 1'b1;
          nxt_state = bmu_pkg::S_F0; // RULE24
        end
      end
      default: begin
        nxt_state = bmu_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    s1_ff <= pins;
    s2_ff <= s1_ff;
    req_q_ff <= req_s;
    if (req_s && !req_q_ff) begin
      plat_ff <= ph_s; // RULE19
    end
    rdata_ff <= RD ? rd_w : 32'h00000000;
    if (RST) begin
      mode_ff <= 8'h00;
      ctl1_ff <= 8'h00;
      ctl2_ff <= 8'h00;
      dsa_ff <= 32'h00000000;
      flags_ff <= 4'h0;
      plat_ff <= 3'h0;
      rdata_ff <= 32'h00000000;
    end else begin
      flags_ff <= nxt_flags;
      if (WR && hit(ADDR, bmu_pkg::A_MODE)) begin
        mode_ff <= WDATA[7:0];
      end
      // set-attention and clear-acknowledge are strobes, not stored
      if (wr_c1) begin
        ctl1_ff <= WDATA[7:0] & 8'hF9;
      end
      if (WR && hit(ADDR, bmu_pkg::A_CTL2)) begin
        ctl2_ff <= WDATA[7:0];
      end
      if (WR && hit(ADDR, bmu_pkg::A_DSA)) begin
        dsa_ff <= WDATA;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_ff <= bmu_pkg::S_IDLE;
      {ptr_ff, opd_ff, nad_ff, fadr_ff, dadr_ff} <= 160'h0;
      {cmd_ff, cnt_ff, dwd_ff, dbo_ff, res_ff, odl_ff} <= 64'h0;
      {freq_ff, dreq_ff, dwe_ff, dio_ff, reqo_ff, acko_ff, atno_ff} <= 7'h00;
      {pho_ff, phoe_ff, dbp_ff, dboe_ff, first_ff, odd_ff} <= 8'h00;
      {flush_ff, hpend_ff, resv_ff, odlv_ff} <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      {ptr_ff, opd_ff, nad_ff, fadr_ff, dadr_ff} <= {nxt_ptr, nxt_opd, nxt_nad, nxt_fadr, nxt_dadr};
      {cmd_ff, cnt_ff, dwd_ff, dbo_ff, res_ff, odl_ff} <=
        {nxt_cmd, nxt_cnt, nxt_dwd, nxt_dbo, nxt_res, nxt_odl};
      {freq_ff, dreq_ff, dwe_ff, dio_ff, reqo_ff, acko_ff, atno_ff} <=
        {nxt_freq, nxt_dreq, nxt_dwe, nxt_dio, nxt_reqo, nxt_acko, nxt_atno};
      {pho_ff, phoe_ff, dbp_ff, dboe_ff, first_ff, odd_ff} <=
        {nxt_pho, nxt_phoe, nxt_dbp, nxt_dboe, nxt_first, nxt_odd};
      {flush_ff, hpend_ff, resv_ff, odlv_ff} <= {nxt_flush, nxt_hpend, nxt_resv, nxt_odlv};
    end
  end

  assign RDATA = rdata_ff;
  assign FETCH_REQ = freq_ff;
  assign FETCH_ADDR = fadr_ff;
  assign DMA_REQ = dreq_ff;
  assign DMA_WE = dwe_ff;
  assign DMA_IO = dio_ff;
  assign DMA_ADDR = dadr_ff;
  assign DMA_WDATA = dwd_ff;
  assign REQ_O = reqo_ff;
  assign ACK_O = acko_ff;
  assign ATN_O = atno_ff;
  assign PHASE_O = pho_ff;
  assign PHASE_OE = phoe_ff;
  assign DB_O = dbo_ff;
  assign DBP_O = dbp_ff;
  assign DB_OE = dboe_ff;
endmodule : bmu_unit
`default_nettype wire

// ### verif/bmu_checker.sv
/* bmu_checker: port assertions for bmu_unit, bound after the module.
   Assumes mode and role registers are written only while the unit is idle. */
`timescale 1ns/1ns
`default_nettype none
module bmu_checker (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic FETCH_REQ,
  input wire logic [31:0] FETCH_ADDR,
  input wire logic FETCH_ACK,
  input wire logic DMA_REQ,
  input wire logic DMA_WE,
  input wire logic DMA_IO,
  input wire logic [31:0] DMA_ADDR,
  input wire logic DMA_ACK,
  input wire logic REQ_I,
  input wire logic ACK_O,
  input wire logic REQ_O,
  input wire logic PHASE_OE
);
  logic dst_ff;
  logic tgt_ff;
  logic seen_ff;
  logic [31:0] last_ff;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      dst_ff <= 1'b0;
      tgt_ff <= 1'b0;
    end else if (WR && ADDR == bmu_pkg::A_MODE) begin
      dst_ff <= WDATA[bmu_pkg::B_DST];
    end else if (WR && ADDR == bmu_pkg::A_CTL1) begin
      tgt_ff <= WDATA[bmu_pkg::B_TGT];
    end
  end
  // a fetch ends the move, so address steps are only tracked inside one move
  always_ff @(posedge CLOCK) begin
    if (DMA_REQ && DMA_ACK) begin
      last_ff <= DMA_ADDR;
    end
    seen_ff <= !RST && !FETCH_REQ && (seen_ff || (DMA_REQ && DMA_ACK));
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_wait;
    FETCH_REQ && !FETCH_ACK;
  endsequence
  sequence s_taken;
    FETCH_REQ && FETCH_ACK;
  endsequence
  AST_FETCH_HOLD: assert property (s_wait |=> FETCH_REQ && $stable(FETCH_ADDR))
    else $error("fetch request moved before ack");
  AST_FETCH_DROP: assert property (s_taken |=> !FETCH_REQ)
    else $error("fetch request held after ack");
  AST_DMA_HOLD: assert property (DMA_REQ && !DMA_ACK |=> DMA_REQ && $stable(DMA_ADDR))
    else $error("memory request moved before ack");
  AST_DMA_DROP: assert property (DMA_REQ && DMA_ACK |=> !DMA_REQ)
    else $error("memory request held after ack");
  AST_DMA_STEP: assert property ($rose(DMA_REQ) && seen_ff |-> DMA_ADDR == last_ff + 32'h1)
    else $error("address did not step by one");
  AST_DMA_SPACE: assert property (DMA_REQ && DMA_WE |-> DMA_IO == dst_ff)
    else $error("receive space select ignored");
  AST_ROLE_PINS: assert property (!tgt_ff && !$past(tgt_ff) |-> !PHASE_OE && !REQ_O)
    else $error("target pins driven outside target role");
  AST_ACK_RISE: assert property ($rose(ACK_O) |-> $past(REQ_I) && $past(REQ_I, 2))
    else $error("acknowledge without request");
endmodule : bmu_checker
bind bmu_unit bmu_checker u_bmu_checker (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR), .FETCH_ACK(FETCH_ACK),
  .DMA_REQ(DMA_REQ), .DMA_WE(DMA_WE), .DMA_IO(DMA_IO), .DMA_ADDR(DMA_ADDR), .DMA_ACK(DMA_ACK),
  .REQ_I(REQ_I), .ACK_O(ACK_O), .REQ_O(REQ_O), .PHASE_OE(PHASE_OE));
`default_nettype wire

// ### verif/bmu_peer.sv
/* bmu_peer: behavioural peer target; sends n bytes from base upward in phase ph.
   Assumes the unit answers each request with one acknowledge level. */
`timescale 1ns/1ns
`default_nettype none
module bmu_peer (
  input wire logic CLOCK,
  input wire logic go,
  input wire logic [2:0] ph,
  input wire logic [7:0] base,
  input wire logic [7:0] n,
  input wire logic ACK_O,
  output logic REQ_I,
  output logic [2:0] PHASE_I,
  output logic [7:0] DB_I,
  output logic DBP_I
);
  logic [7:0] i;
  initial begin
    REQ_I = 1'b0;
    PHASE_I = 3'h0;
    DB_I = 8'hFF;
    DBP_I = 1'b1;
    i = 8'h00;
    forever begin
      @(posedge CLOCK);
      if (!go) i = 8'h00;
      // phase settles a cycle before the request so the latch sees it stable
      if (go && PHASE_I == ph && i < n && !ACK_O) begin
        DB_I <= base + i;
        DBP_I <= ~^(base + i);
        REQ_I <= 1'b1;
        @(posedge CLOCK);
        while (go && !ACK_O) @(posedge CLOCK);
        REQ_I <= 1'b0;
        DB_I <= ~(base + i);
        DBP_I <= ~DBP_I;
        i = i + 8'h01;
        while (go && ACK_O) @(posedge CLOCK);
      end
      if (go) PHASE_I <= ph;
    end
  end
endmodule : bmu_peer
`default_nettype wire

// ### verif/bmu_unit_tb.sv
/* bmu_unit_tb: self-checking bench with fetch and memory responders and a peer.
   Assumes initiator role and receive moves; unmapped fetches stop the script. */
`timescale 1ns/1ns
`default_nettype none
module bmu_unit_tb;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic FETCH_ACK = 1'b0;
  logic [31:0] FETCH_DATA = 32'h0;
  logic DMA_ACK = 1'b0;
  logic CONN_INIT = 1'b0;
  logic go = 1'b0;
  logic [2:0] pph = 3'h0;
  logic [7:0] pbase = 8'h00;
  logic [7:0] pn = 8'h00;
  wire logic [31:0] RDATA, FETCH_ADDR, DMA_ADDR;
  wire logic FETCH_REQ, DMA_REQ, DMA_WE, DMA_IO, ACK_O, REQ_I, DBP_I;
  wire logic [2:0] PHASE_I;
  wire logic [7:0] DMA_WDATA, DB_I;
  logic [31:0] mem [logic [31:0]];
  logic [40:0] got [$];
  logic [31:0] seed = 32'hE939;
  int n_errors = 0;
  int tests_run = 0;
  always #2 CLOCK = ~CLOCK;
  bmu_unit u_bmu_unit (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR), .FETCH_ACK(FETCH_ACK),
    .FETCH_DATA(FETCH_DATA), .DMA_REQ(DMA_REQ), .DMA_WE(DMA_WE), .DMA_IO(DMA_IO),
    .DMA_ADDR(DMA_ADDR), .DMA_WDATA(DMA_WDATA), .DMA_ACK(DMA_ACK), .DMA_RDATA(8'h00),
    .CONN_TARGET(1'b0), .CONN_INIT(CONN_INIT), .REQ_I(REQ_I), .ACK_I(1'b0), .ATN_I(1'b0),
    .PHASE_I(PHASE_I), .DB_I(DB_I), .DBP_I(DBP_I), .REQ_O(), .ACK_O(ACK_O), .ATN_O(),
    .PHASE_O(), .PHASE_OE(), .DB_O(), .DBP_O(), .DB_OE());
  bmu_peer u_bmu_peer (.CLOCK(CLOCK), .go(go), .ph(pph), .base(pbase), .n(pn), .ACK_O(ACK_O),
    .REQ_I(REQ_I), .PHASE_I(PHASE_I), .DB_I(DB_I), .DBP_I(DBP_I));
  // unmapped words decode as non-move and halt the unit
  always @(posedge CLOCK) begin
    FETCH_ACK <= FETCH_REQ && !FETCH_ACK;
    FETCH_DATA <= mem.exists(FETCH_ADDR) ? mem[FETCH_ADDR] : 32'hC0000000;
    DMA_ACK <= DMA_REQ && !DMA_ACK;
    if (DMA_REQ && !DMA_ACK && DMA_WE)
      got.push_back({DMA_IO, DMA_ADDR, DMA_WDATA});
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(negedge CLOCK);
    d = RDATA;
  endtask : rd
  task automatic run(input logic [31:0] w0, input logic [31:0] w1, input logic [2:0] ph,
      input int n, input logic [31:0] dst, input logic [3:0] st);
    logic [31:0] d;
    int en;
    int k;
    seed = lfsr(seed);
    mem[32'h1000] = w0;
    mem[32'h1004] = w1;
    got.delete();
    pbase <= seed[7:0];
    pph <= ph;
    pn <= n[7:0];
    go <= 1'b1;
    wr(bmu_pkg::A_PTR, 32'h1000);
    k = 0;
    d = 32'h0;
    while (d[11:8] !== bmu_pkg::S_HALT && k < 300) begin
      rd(bmu_pkg::A_STAT, d);
      k++;
    end
    go <= 1'b0;
    chk(d[11:8], bmu_pkg::S_HALT);
    chk(d[3:0], st);
    en = st[bmu_pkg::F_DONE] ? n - (!w0[27] && n[0]) : 0;
    chk(got.size(), en);
    for (int i = 0; i < got.size() && i < en; i++)
      chk(got[i], {1'b1, dst + i, seed[7:0] + i[7:0]});
    rd(bmu_pkg::A_PHR, d);
    if (st != 4'h1)
      chk(d[2:0], ph);
    if (st[bmu_pkg::F_DONE] && en < n)
      chk(d[16:8], {1'b1, seed[7:0] + en[7:0]});
    wr(bmu_pkg::A_STAT, 32'hF);
  endtask : run
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    rd(bmu_pkg::A_DSA, d);
    chk(d, 32'h0);
    wr(bmu_pkg::A_DSA, 32'h100);
    rd(bmu_pkg::A_DSA, d);
    chk(d, 32'h100);
    rd(8'h3C, d);
    chk(d, 32'h0);
    wr(bmu_pkg::A_MODE, 32'h10);
    mem[32'hF8] = 32'h2;
    mem[32'hFC] = 32'h4000;
    mem[32'h300] = 32'h3000;
    // one addressing bit at most in every command word
    run(32'h09000003, 32'h2000, 3'h1, 3, 32'h2000, 4'h1);
    CONN_INIT <= 1'b1;
    run(32'h09000003, 32'h2000, 3'h1, 3, 32'h2000, 4'h9);
    run(32'h19000055, 32'h5AFFFFF8, 3'h1, 2, 32'h4000, 4'h9);
    run(32'h29000002, 32'h300, 3'h1, 2, 32'h3000, 4'h9);
    run(32'h09000002, 32'h2000, 3'h0, 2, 32'h2000, 4'h2);
    run(32'h0F000001, 32'h2000, 3'h7, 1, 32'h2000, 4'h9);
    chk(ACK_O, 1'b1);
    wr(bmu_pkg::A_CTL1, 32'h4);
    run(32'h01000003, 32'h2000, 3'h1, 3, 32'h2000, 4'h9);
    end_of_test();
  end
  initial begin
    #80000;
    n_errors++;
    end_of_test();
  end
endmodule : bmu_unit_tb
`default_nettype wire
